// ### inc/oac_cfg.svh
// Purpose: Offsets, field positions, reset values and timing figures
// Assumes: Byte addresses on a 32-bit classic Wishbone bus
// Notes: Definitions only
`ifndef OAC_CFG_SVH
`define OAC_CFG_SVH
// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define OAC_CLK_PERIOD_NS 8
`define OAC_PASS_TIME_NS 1000
`define OAC_STAB_TIME_NS 10000
`define OAC_CNT_W 16
// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define OAC_ADDR_W 8
`define OAC_ADDR_CTRL 8'h00
`define OAC_ADDR_IRQ_STAT 8'h04
`define OAC_ADDR_IRQ_MASK 8'h08
`define OAC_CTRL_RESET 8'h00
`define OAC_BIT_DONE 7
`define OAC_BIT_REQ 6
`define OAC_BIT_AVG 5
`define OAC_BIT_PWR 4
`define OAC_BIT_GAIN 3
// ----------------------------------------------------------------
// Interrupt bits and calibration figures
// ----------------------------------------------------------------
`define OAC_IRQ_W 2
`define OAC_IRQ_RESET 2'h0
`define OAC_IRQ_CAL 0
`define OAC_IRQ_READY 1
`define OAC_AVG_PASSES 16
`define OAC_AVG_SHIFT 4
`define OAC_PASS_CNT_W 5
`define OAC_TRIM_W 6
`define OAC_TRIM_ZERO 6'h00
`endif

// ### inc/oac_pkg.sv
// Purpose: Types shared by the amplifier control files
// Assumes: oac_cfg.svh gives the widths
// Notes: States are one-hot
`default_nettype none
`include "oac_cfg.svh"
package oac_pkg;
    // Sequencer states
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_RUN = 3'b010,
        SEQ_DONE = 3'b100
    } oac_seq_state_t;

    // Control bits held by software
    typedef struct packed {
        logic request;
        logic average;
        logic power;
        logic gainHigh;
    } oac_ctrl_t;

    // Bundle toward the analog amplifier
    typedef struct packed {
        logic powerEn;
        logic outEn;
        logic gainHigh;
        logic trimApply;
        logic [`OAC_TRIM_W-1:0] trim;
    } oac_amp_ctrl_t;

    // Sequencer state
    typedef struct packed {
        oac_seq_state_t state;
        logic reqPrev;
        logic [`OAC_CNT_W-1:0] cycCnt;
        logic [`OAC_PASS_CNT_W-1:0] passCnt;
        logic [`OAC_TRIM_W+`OAC_AVG_SHIFT-1:0] acc;
        logic [`OAC_TRIM_W-1:0] trim;
        logic done;
        logic doneEvt;
    } oac_seq_st_t;

    // Stabilization timer state
    typedef struct packed {
        logic [`OAC_CNT_W-1:0] cnt;
        logic ready;
        logic readyEvt;
    } oac_stab_st_t;

    // Register file and bus state
    typedef struct packed {
        oac_ctrl_t ctrl;
        logic [`OAC_IRQ_W-1:0] irqStat;
        logic [`OAC_IRQ_W-1:0] irqMask;
        logic ack;
        logic [31:0] rdata;
        oac_amp_ctrl_t amp;
    } oac_top_st_t;
endpackage : oac_pkg
`default_nettype wire

// ### rtl/oac_cal_seq.sv
// Purpose: Offset compensation sequencer, one-shot or averaged
// Assumes: sample holds the measured correction of the current pass
// Notes: Stalls while the amplifier is not usable
`timescale 1ns/1ps
`default_nettype none
`include "oac_cfg.svh"
module oac_cal_seq #(
    parameter int PASS_CYC = 125
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic request,
    input wire logic average,
    input wire logic enable,
    input wire logic [`OAC_TRIM_W-1:0] sample,
    output logic [`OAC_TRIM_W-1:0] trim,
    output logic done,
    output logic doneEvt,
    output logic busy
);
    import oac_pkg::*;

    oac_seq_st_t st_reg;
    oac_seq_st_t st_next;
    logic [`OAC_TRIM_W+`OAC_AVG_SHIFT-1:0] accSum;
    logic [`OAC_PASS_CNT_W-1:0] lastPass;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.reqPrev = request;
        st_next.doneEvt = 1'b0;
        accSum = st_reg.acc + {{`OAC_AVG_SHIFT{1'b0}}, sample};
        lastPass = average ? `OAC_PASS_CNT_W'(`OAC_AVG_PASSES - 1) : '0; // R6
        case (st_reg.state)
            SEQ_IDLE: begin
                if (request && !st_reg.reqPrev) begin // R1 R4
                    st_next.state = SEQ_RUN;
                    st_next.cycCnt = '0;
                    st_next.passCnt = '0;
                    st_next.acc = '0;
                end
            end
            SEQ_RUN: begin
                if (enable) begin // R14
                    st_next.cycCnt = st_reg.cycCnt + 1'b1;
                    if (st_reg.cycCnt == `OAC_CNT_W'(PASS_CYC - 1)) begin
                        st_next.cycCnt = '0;
                        st_next.acc = accSum;
                        st_next.passCnt = st_reg.passCnt + 1'b1;
                        if (st_reg.passCnt == lastPass) begin // R6
                            st_next.state = SEQ_DONE;
                            st_next.done = 1'b1; // R2
                            st_next.doneEvt = 1'b1;
                            st_next.trim = average ?
                                accSum[`OAC_TRIM_W+`OAC_AVG_SHIFT-1:`OAC_AVG_SHIFT] : sample;
                        end
                    end
                end
            end
            SEQ_DONE: begin
                st_next.state = SEQ_DONE;
            end
            default: begin
                st_next.state = SEQ_IDLE;
            end
        endcase
        // Dropping the request aborts and forgets the result
        if (!request) begin // R5 R14
            st_next.state = SEQ_IDLE;
            st_next.trim = `OAC_TRIM_ZERO;
            st_next.done = 1'b0;
            st_next.doneEvt = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= '{state: SEQ_IDLE, trim: `OAC_TRIM_ZERO, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign trim = st_reg.trim;
    assign done = st_reg.done;
    assign doneEvt = st_reg.doneEvt;
    assign busy = (st_reg.state == SEQ_RUN);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    pass_limit_a: assert property (busy && !average |-> st_reg.passCnt == '0) // R6
        else $error("one-shot ran more than one pass");
    evt_done_a: assert property (doneEvt |-> done && $past(request)) // R2
        else $error("done pulse without done flag");
endmodule : oac_cal_seq
`default_nettype wire

// ### rtl/oac_stab_timer.sv
// Purpose: Holds the amplifier unusable until it has settled
// Assumes: halt is high during Halt mode
// Notes: Also runs after each power-on
`timescale 1ns/1ps
`default_nettype none
`include "oac_cfg.svh"
module oac_stab_timer #(
    parameter int STAB_CYC = 1250
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic halt,
    input wire logic powerOn,
    output logic ready,
    output logic readyEvt
);
    import oac_pkg::*;

    oac_stab_st_t st_reg;
    oac_stab_st_t st_next;

    // ----------------------------------------------------------------
    // Settling count
    // ----------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.readyEvt = 1'b0;
        if (halt || !powerOn) begin // R11
            st_next.cnt = '0;
            st_next.ready = 1'b0;
        end else if (!st_reg.ready) begin
            st_next.cnt = st_reg.cnt + 1'b1;
            if (st_reg.cnt == `OAC_CNT_W'(STAB_CYC - 1)) begin
                st_next.ready = 1'b1;
                st_next.readyEvt = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign ready = st_reg.ready;
    assign readyEvt = st_reg.readyEvt;
endmodule : oac_stab_timer
`default_nettype wire

// ### rtl/oac_top.sv
// Purpose: Control, status and offset calibration of the amplifier
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses
// Notes: Only byte lane 0 carries register bits

`timescale 1ns/1ps
`default_nettype none
`include "oac_cfg.svh"

// Function
// R1: Request bit rising starts compensation cycle
// R2: Hardware sets done flag at completion
// R3: Compensation applied only while request set
// R4: Each zero-to-one request starts fresh cycle
// R5: Clearing request resets compensation values
// R6: Average bit selects 16 passes, else one
// R7: Done reads zero unless request and complete
// R8: Power bit powers amplifier, connects pins
// R9: Amplifier off leaves output pin floating
// R10: Gain bit selects high closed-loop gain
// R11: Halt disables amplifier, settle after wake
// R12: Software writes zeros to reserved bits
// R13: Register resets zero, done bit read-only
// R14: Fixed pass length, abort restarts cleanly
module oac_top #(
    parameter int PASS_CYC = (`OAC_PASS_TIME_NS + `OAC_CLK_PERIOD_NS - 1)
        / `OAC_CLK_PERIOD_NS,
    parameter int STAB_CYC = (`OAC_STAB_TIME_NS + `OAC_CLK_PERIOD_NS - 1)
        / `OAC_CLK_PERIOD_NS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`OAC_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic haltMode,
    input wire logic [`OAC_TRIM_W-1:0] offsetSample,
    output oac_pkg::oac_amp_ctrl_t ampCtrl,
    output logic ampReady,
    output logic irq
);
    import oac_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    oac_top_st_t st_reg;
    oac_top_st_t st_next;

    logic [`OAC_TRIM_W-1:0] seqTrim;
    logic seqDone;
    logic seqDoneEvt;
    logic seqBusy;
    logic stabReady;
    logic stabEvt;

    logic busReq;
    logic wrStrobe;
    logic wrCtrl;
    logic wrStat;
    logic wrMask;
    logic [7:0] ctrlView;
    logic [`OAC_IRQ_W-1:0] events;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function automatic logic hitAddr(
        input logic [`OAC_ADDR_W-1:0] adr,
        input logic [`OAC_ADDR_W-1:0] target
    );
        hitAddr = (adr == target);
    endfunction : hitAddr

    // ----------------------------------------------------------------
    // Calibration sequencer
    // ----------------------------------------------------------------
    oac_cal_seq #(
        .PASS_CYC(PASS_CYC)
    ) u_seq (
        .clk(clk),
        .rst(rst),
        .request(st_reg.ctrl.request),
        .average(st_reg.ctrl.average),
        .enable(stabReady),
        .sample(offsetSample),
        .trim(seqTrim),
        .done(seqDone),
        .doneEvt(seqDoneEvt),
        .busy(seqBusy)
    );

    // ----------------------------------------------------------------
    // Settling timer after halt or power-on
    // ----------------------------------------------------------------
    oac_stab_timer #(
        .STAB_CYC(STAB_CYC)
    ) u_stab (
        .clk(clk),
        .rst(rst),
        .halt(haltMode),
        .powerOn(st_reg.ctrl.power),
        .ready(stabReady),
        .readyEvt(stabEvt)
    );

    // ----------------------------------------------------------------
    // Bus strobes
    // ----------------------------------------------------------------

    // Request pending, write lands on the acknowledged edge
    assign busReq = wb_cyc_i && wb_stb_i;
    assign wrStrobe = busReq && wb_we_i && st_reg.ack && wb_sel_i[0];
    assign wrCtrl = wrStrobe && hitAddr(wb_adr_i, `OAC_ADDR_CTRL);
    assign wrStat = wrStrobe && hitAddr(wb_adr_i, `OAC_ADDR_IRQ_STAT);
    assign wrMask = wrStrobe && hitAddr(wb_adr_i, `OAC_ADDR_IRQ_MASK);

    // Control register as software sees it
    always_comb begin
        ctrlView = `OAC_CTRL_RESET;
        ctrlView[`OAC_BIT_DONE] = seqDone && st_reg.ctrl.request; // R7
        ctrlView[`OAC_BIT_REQ] = st_reg.ctrl.request;
        ctrlView[`OAC_BIT_AVG] = st_reg.ctrl.average;
        ctrlView[`OAC_BIT_PWR] = st_reg.ctrl.power;
        ctrlView[`OAC_BIT_GAIN] = st_reg.ctrl.gainHigh;
    end

    // Sticky event sources
    always_comb begin
        events = '0;
        events[`OAC_IRQ_CAL] = seqDoneEvt; // R2
        events[`OAC_IRQ_READY] = stabEvt;
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_next = st_reg;

        // One-cycle acknowledge, data captured with it
        st_next.ack = busReq && !st_reg.ack;
        if (busReq && !st_reg.ack) begin
            if (hitAddr(wb_adr_i, `OAC_ADDR_CTRL)) begin
                st_next.rdata = {24'h000000, ctrlView}; // R12
            end else if (hitAddr(wb_adr_i, `OAC_ADDR_IRQ_STAT)) begin
                st_next.rdata = {{(32-`OAC_IRQ_W){1'b0}}, st_reg.irqStat};
            end else if (hitAddr(wb_adr_i, `OAC_ADDR_IRQ_MASK)) begin
                st_next.rdata = {{(32-`OAC_IRQ_W){1'b0}}, st_reg.irqMask};
            end else begin
                st_next.rdata = 32'h00000000;
            end
        end

        // Writable bits only, done bit is ignored
        if (wrCtrl) begin // R13
            st_next.ctrl.request = wb_dat_i[`OAC_BIT_REQ];
            st_next.ctrl.average = wb_dat_i[`OAC_BIT_AVG];
            st_next.ctrl.power = wb_dat_i[`OAC_BIT_PWR];
            st_next.ctrl.gainHigh = wb_dat_i[`OAC_BIT_GAIN]; // R10
        end

        // Write one to clear, a new event wins
        st_next.irqStat = st_reg.irqStat;
        if (wrStat) begin
            st_next.irqStat = st_reg.irqStat & ~wb_dat_i[`OAC_IRQ_W-1:0];
        end
        st_next.irqStat = st_next.irqStat | events;

        if (wrMask) begin
            st_next.irqMask = wb_dat_i[`OAC_IRQ_W-1:0];
        end

        // Amplifier drive, off in halt
        st_next.amp.powerEn = st_reg.ctrl.power && !haltMode; // R8 R11
        st_next.amp.outEn = st_reg.ctrl.power && !haltMode; // R9
        st_next.amp.gainHigh = st_reg.ctrl.gainHigh; // R10
        // Correction only while requested
        st_next.amp.trimApply = st_reg.ctrl.request && seqDone; // R3
        st_next.amp.trim = st_reg.ctrl.request ? seqTrim : `OAC_TRIM_ZERO; // R5
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= '{ // R13
                ctrl: '0,
                irqStat: `OAC_IRQ_RESET,
                irqMask: `OAC_IRQ_RESET,
                ack: 1'b0,
                rdata: 32'h00000000,
                amp: '{trim: `OAC_TRIM_ZERO, default: 1'b0}
            };
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign wb_ack_o = st_reg.ack;
    assign wb_dat_o = st_reg.rdata;
    assign ampCtrl = st_reg.amp;
    assign ampReady = stabReady && st_reg.amp.powerEn; // R11
    assign irq = |(st_reg.irqStat & st_reg.irqMask);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Bus answer timing
    ack_latency_a: assert property (busReq && !wb_ack_o |=> wb_ack_o)
        else $error("no acknowledge one cycle after request");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge held over two cycles");

    // Start and restart of compensation
    start_on_rise_a: assert property ($rose(st_reg.ctrl.request) |=> seqBusy) // R1
        else $error("request rise did not start a cycle");
    restart_fresh_a: assert property ($rose(st_reg.ctrl.request) |=> !seqDone) // R4
        else $error("new cycle kept an old done state");

    // Completion and done view
    done_irq_a: assert property (seqDoneEvt |=> st_reg.irqStat[`OAC_IRQ_CAL]) // R2
        else $error("completion did not set status");
    done_view_a: assert property (!st_reg.ctrl.request |-> !ctrlView[`OAC_BIT_DONE]) // R7
        else $error("done reads one without request");
    done_clear_a: assert property ($fell(st_reg.ctrl.request) |=> !seqDone) // R5
        else $error("done survived clearing the request");

    // Correction gating
    trim_reset_a: assert property (!st_reg.ctrl.request |=>
        ampCtrl.trim == `OAC_TRIM_ZERO && !ampCtrl.trimApply) // R3
        else $error("correction applied without request");

    // Power, pins, halt and gain
    power_halt_a: assert property (haltMode |=> !ampCtrl.powerEn && !ampReady) // R11
        else $error("amplifier active in halt");
    hiz_off_a: assert property (!ampCtrl.powerEn |-> !ampCtrl.outEn) // R9
        else $error("output driven while amplifier off");
    power_follow_a: assert property (wrCtrl && !haltMode ##1 !haltMode
        |=> ampCtrl.powerEn == $past(wb_dat_i[`OAC_BIT_PWR], 2)) // R8
        else $error("power enable does not follow control bit");
    gain_write_a: assert property (wrCtrl |=>
        st_reg.ctrl.gainHigh == $past(wb_dat_i[`OAC_BIT_GAIN])) // R10
        else $error("gain bit not written");

    // Cycles since the last halt, for the wake cover
    logic [11:0] wakeCnt_reg;
    logic wakeSeen_reg;
    always_ff @(posedge clk) begin
        if (rst) begin
            wakeCnt_reg <= 12'h000;
            wakeSeen_reg <= 1'b0;
        end else if (haltMode) begin
            wakeCnt_reg <= 12'h000;
            wakeSeen_reg <= 1'b1;
        end else if (wakeCnt_reg != 12'hFFF) begin
            wakeCnt_reg <= wakeCnt_reg + 12'h001;
        end
    end

    // Main scenarios
    cal_done_c: cover property (seqDoneEvt && st_reg.ctrl.average);
    cal_abort_c: cover property (seqBusy ##1 !st_reg.ctrl.request);
    halt_wake_c: cover property (wakeSeen_reg && !haltMode && stabEvt
        && wakeCnt_reg <= 12'h7D0);
    irq_raise_c: cover property ($rose(irq));

endmodule : oac_top
`default_nettype wire

// ### verification/test_oac_top.sv
// Purpose: Self-checking bench of the amplifier control and calibration block
// Assumes: Short pass and settle counts handed to the top as parameters
// Notes: Registers reached over classic Wishbone, one transfer at a time
`timescale 1ns/1ps
`default_nettype none
`include "oac_cfg.svh"
module test_oac_top;
    import oac_pkg::*;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    localparam int PASS = 4;
    localparam int STAB = 8;
    localparam int LIMIT = 20000;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [`OAC_ADDR_W-1:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    logic [31:0] busData;
    logic ack;
    logic haltMode = 1'b0;
    logic [`OAC_TRIM_W-1:0] sample = 6'h00;
    oac_amp_ctrl_t ampCtrl;
    logic ampReady;
    logic irq;
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;

    oac_top #(.PASS_CYC(PASS), .STAB_CYC(STAB)) DUT (
        .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .haltMode(haltMode), .offsetSample(sample),
        .ampCtrl(ampCtrl), .ampReady(ampReady), .irq(irq)
    );

    // Free-running clock and hang guard
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            err_total++;
            conclude();
        end
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic conclude();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One classic cycle, held until ack is sampled high
    task automatic wbXfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1);
        chk("bus ack edges", 32'h00000002, n);
        busData = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wbXfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wbXfer(1'b1, a, d, 4'hF);
    endtask : wr

    // Read compare of one register
    task automatic chkReg(input string name, input logic [7:0] a, input logic [31:0] exp);
        wbXfer(1'b0, a, 32'h00000000, 4'hF);
        chk(name, exp, busData);
    endtask : chkReg

    // Settled look after n edges
    task automatic waitCyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : waitCyc

    task automatic waitApply(input int lim);
        int n;
        n = 0;
        while (ampCtrl.trimApply !== 1'b1 && n < lim) begin
            waitCyc(1);
            n++;
        end
    endtask : waitApply

    task automatic setSample(input logic [5:0] v);
        @(posedge clk);
        sample <= v;
    endtask : setSample

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic testReset();
        chkReg("ctrl", `OAC_ADDR_CTRL, 32'h00000000);
        chkReg("irq status", `OAC_ADDR_IRQ_STAT, 32'h00000000);
        chkReg("irq mask", `OAC_ADDR_IRQ_MASK, 32'h00000000);
        chk("ampCtrl", 32'h00000000, {22'h0, ampCtrl});
        chk("irq", 32'h00000000, {31'h0, irq});
        $display("testReset finished");
    endtask : testReset

    task automatic testAccess();
        wr(`OAC_ADDR_CTRL, 32'h0000008F);
        chkReg("ctrl ro bits", `OAC_ADDR_CTRL, 32'h00000008);
        wbXfer(1'b1, `OAC_ADDR_CTRL, 32'h00000038, 4'hE);
        chkReg("ctrl no lane", `OAC_ADDR_CTRL, 32'h00000008);
        waitCyc(2);
        chk("gainHigh set", 32'h00000001, {31'h0, ampCtrl.gainHigh});
        chkReg("unmapped", 8'h0C, 32'h00000000);
        wr(`OAC_ADDR_CTRL, 32'h00000000);
        waitCyc(2);
        chk("gainHigh clear", 32'h00000000, {31'h0, ampCtrl.gainHigh});
        $display("testAccess finished");
    endtask : testAccess

    task automatic testPower();
        wr(`OAC_ADDR_CTRL, 32'h00000010);
        waitCyc(2);
        chk("power on", 32'h00000003, {30'h0, ampCtrl.powerEn, ampCtrl.outEn});
        chk("ready early", 32'h00000000, {31'h0, ampReady});
        waitCyc(STAB + 4);
        chk("ready", 32'h00000001, {31'h0, ampReady});
        @(posedge clk);
        haltMode <= 1'b1;
        waitCyc(3);
        chk("halt off", 32'h00000000, {30'h0, ampCtrl.powerEn, ampCtrl.outEn});
        chk("halt ready", 32'h00000000, {31'h0, ampReady});
        @(posedge clk);
        haltMode <= 1'b0;
        waitCyc(STAB - 3);
        chk("wake settling", 32'h00000000, {31'h0, ampReady});
        waitCyc(8);
        chk("wake ready", 32'h00000001, {31'h0, ampReady});
        chk("wake on", 32'h00000003, {30'h0, ampCtrl.powerEn, ampCtrl.outEn});
        $display("testPower finished");
    endtask : testPower

    task automatic testOneShot();
        setSample(6'h15);
        wr(`OAC_ADDR_CTRL, 32'h00000050);
        chk("apply early", 32'h00000000, {31'h0, ampCtrl.trimApply});
        chkReg("ctrl running", `OAC_ADDR_CTRL, 32'h00000050);
        waitApply(200);
        chk("apply", 32'h00000001, {31'h0, ampCtrl.trimApply});
        chk("trim", 32'h00000015, {26'h0, ampCtrl.trim});
        chkReg("ctrl done", `OAC_ADDR_CTRL, 32'h000000D0);
        waitCyc(20);
        chk("apply held", 32'h00000001, {31'h0, ampCtrl.trimApply});
        $display("testOneShot finished");
    endtask : testOneShot

    task automatic testIrq();
        chkReg("status both", `OAC_ADDR_IRQ_STAT, 32'h00000003);
        chk("irq masked", 32'h00000000, {31'h0, irq});
        wr(`OAC_ADDR_IRQ_MASK, 32'h00000001);
        waitCyc(2);
        chk("irq cal", 32'h00000001, {31'h0, irq});
        wr(`OAC_ADDR_IRQ_STAT, 32'h00000001);
        waitCyc(2);
        chk("irq cleared", 32'h00000000, {31'h0, irq});
        chkReg("status left", `OAC_ADDR_IRQ_STAT, 32'h00000002);
        wr(`OAC_ADDR_IRQ_MASK, 32'h00000003);
        waitCyc(2);
        chk("irq ready", 32'h00000001, {31'h0, irq});
        wr(`OAC_ADDR_IRQ_STAT, 32'h00000002);
        waitCyc(2);
        chk("irq idle", 32'h00000000, {31'h0, irq});
        $display("testIrq finished");
    endtask : testIrq

    task automatic testClear();
        wr(`OAC_ADDR_CTRL, 32'h00000010);
        waitCyc(3);
        chk("clear apply", 32'h00000000, {31'h0, ampCtrl.trimApply});
        chk("clear trim", 32'h00000000, {26'h0, ampCtrl.trim});
        chkReg("ctrl cleared", `OAC_ADDR_CTRL, 32'h00000010);
        setSample(6'h0A);
        wr(`OAC_ADDR_CTRL, 32'h00000050);
        waitApply(200);
        chk("fresh trim", 32'h0000000A, {26'h0, ampCtrl.trim});
        $display("testClear finished");
    endtask : testClear

    task automatic testAverage();
        wr(`OAC_ADDR_CTRL, 32'h00000030);
        setSample(6'h21);
        wr(`OAC_ADDR_CTRL, 32'h00000070);
        waitCyc(10);
        wr(`OAC_ADDR_CTRL, 32'h00000030);
        chk("abort apply", 32'h00000000, {31'h0, ampCtrl.trimApply});
        wr(`OAC_ADDR_CTRL, 32'h00000070);
        @(posedge clk);
        haltMode <= 1'b1;
        waitCyc(PASS * 20);
        chk("avg stalled", 32'h00000000, {31'h0, ampCtrl.trimApply});
        @(posedge clk);
        haltMode <= 1'b0;
        waitApply(400);
        chk("avg trim", 32'h00000021, {26'h0, ampCtrl.trim});
        chkReg("ctrl avg done", `OAC_ADDR_CTRL, 32'h000000F0);
        $display("testAverage finished");
    endtask : testAverage

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        testReset();
        testAccess();
        testPower();
        testOneShot();
        testIrq();
        testClear();
        testAverage();
        conclude();
    end
endmodule : test_oac_top
`default_nettype wire
